// File: ebha_defs.svh
// Purpose: Constants for the external bus handshake arbiter.
// Assumes: One 20 MHz clock, synchronous active-low reset.
// Notes: The block's counts, widths and fixed DMA channel numbers live here.
//
// What this block does
// - Low acknowledge from outside holds our external access open.
// - Drive acknowledge low to stretch synchronous access of internal memory.
// - As bus slave, pull master's acknowledge low for wait states.
// - Bus master keeps acknowledge at its last driven level.
// - Bus suspend sampled low floats address, data, selects, strobes next cycle.
// - External access under bus suspend stalls until suspend releases.
// - Each of three interrupt inputs is edge or level triggered.
// - Each of four flag pins is input or output by control bit.
// - Timer reaching zero while enabled pulses timer expired four cycles.
// - On host request, master floats bus, then asserts host grant.
// - Host bus request beats every multiprocessor bus request.
// - Host grant stays low until host releases its request.
// - Only the bus master drives host grant; others monitor it.
// - Host ready driven low to add wait states to host access.
// - Host ready is open-drain unless the drive select bit is set.
// - Host ready is driven only while chip select and host request assert.
// - DMA pair 1 serves channel 7, pair 2 serves channel 6.
// - Drive only own request line by number; monitor the others.
// - Number n selects line n, zero means single processor, reset only.
// - Priority select high means rotating, low means fixed priority.
`ifndef EBHA_DEFS_SVH
`define EBHA_DEFS_SVH
`define EBHA_NUM_REQ 6
`define EBHA_NUM_IRQ 3
`define EBHA_NUM_FLAG 4
`define EBHA_EXPIRE_CYC 3'h4
`define EBHA_TMR_W 32
`define EBHA_ID_SINGLE 3'h0
`define EBHA_DMA_CH_PAIR1 3'h7
`define EBHA_DMA_CH_PAIR2 3'h6
`endif

// File: ebha_pkg.sv
// Purpose: Types for the external bus handshake arbiter.
// Assumes: Constants come from ebha_defs.svh.
// Notes: Bus drive enables travel together as one struct.
`include "ebha_defs.svh"
package ebha_pkg;
  typedef enum logic [1:0] {
    EBHA_OWN_SLAVE,
    EBHA_OWN_MASTER,
    EBHA_OWN_HOST
  } ebha_own_t;
  typedef struct packed {
    logic addr_oe;
    logic data_oe;
    logic sel_oe;
    logic strobe_oe;
  } ebha_bus_oe_t;
endpackage

// File: ebha_arbiter.sv
// Purpose: Bus ownership, wait-state and side-signal handshake logic.
// Assumes: All inputs are synchronous to clk; pins split as in/out/oe.
// Notes: Outputs are all registered, so every pin change lands a cycle late.
`timescale 1ns/100ps
`default_nettype none
`include "ebha_defs.svh"
module ebha_arbiter
  import ebha_pkg::*;
(
  // Clock, reset and enable.
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // Configuration straps.
  input wire logic [2:0] multiproc_number,
  input wire logic rotating_priority_select,
  input wire logic host_ack_drive_select,
  // Core access requests.
  input wire logic core_ext_req,
  input wire logic core_bus_want,
  output logic core_ext_done,
  output logic core_bus_owner,
  // Memory acknowledge pin.
  input wire logic ack_in,
  output logic ack_out,
  output logic ack_oe,
  input wire logic slave_sync_busy,
  // Bus suspend and bus drive enables.
  input wire logic bus_suspend_in_n,
  output ebha_bus_oe_t bus_oe,
  // Host handshake.
  input wire logic host_bus_request_n,
  input wire logic host_cs_n,
  input wire logic host_access_busy,
  input wire logic host_bus_grant_in_n,
  output logic host_bus_grant_n,
  output logic host_bus_grant_oe,
  output logic host_ready_out_n,
  output logic host_ready_oe,
  // Multiprocessor bus requests.
  input wire logic [`EBHA_NUM_REQ-1:0] multiproc_bus_request_in_n,
  output logic [`EBHA_NUM_REQ-1:0] multiproc_bus_request_n,
  output logic [`EBHA_NUM_REQ-1:0] multiproc_bus_request_oe,
  // Interrupt requests.
  input wire logic [`EBHA_NUM_IRQ-1:0] irq_in_n,
  input wire logic [`EBHA_NUM_IRQ-1:0] irq_edge_mode,
  input wire logic [`EBHA_NUM_IRQ-1:0] irq_clear,
  output logic [`EBHA_NUM_IRQ-1:0] irq_pending,
  // Flag pins.
  input wire logic [`EBHA_NUM_FLAG-1:0] flag_dir_out,
  input wire logic [`EBHA_NUM_FLAG-1:0] flag_out_value,
  input wire logic [`EBHA_NUM_FLAG-1:0] flag_in,
  output logic [`EBHA_NUM_FLAG-1:0] flag_out,
  output logic [`EBHA_NUM_FLAG-1:0] flag_oe,
  output logic [`EBHA_NUM_FLAG-1:0] flag_cond,
  // Timer.
  input wire logic timer_enable,
  input wire logic [`EBHA_TMR_W-1:0] timer_count_value,
  output logic timer_expired_out,
  // External DMA pairs: index 0 is pair 1, index 1 is pair 2.
  input wire logic [1:0] ext_dma_request_n,
  input wire logic [1:0] dma_grant_ok,
  output logic [1:0] ext_dma_grant_n,
  output logic [1:0] ext_dma_grant_oe,
  output logic [2:0] dma_req_channel_pair1,
  output logic [2:0] dma_req_channel_pair2,
  output logic [1:0] dma_req_valid
);

  // One-hot line mask for a processor number; zero gives no line.
  function automatic logic [`EBHA_NUM_REQ-1:0] line_of(input logic [2:0] n);
    logic [`EBHA_NUM_REQ-1:0] m;
    m = '0;
    for (int i = 0; i < `EBHA_NUM_REQ; i++) begin
      if (n == 3'(i + 1)) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction

  logic [2:0] my_num_reg;
  logic [`EBHA_NUM_REQ-1:0] my_line;
  logic single_proc;
  ebha_own_t own_reg, own_next;
  logic [2:0] last_master_reg;
  logic suspend_reg;
  logic ack_keep_reg;
  logic host_req;
  logic my_req;
  logic win;
  logic [`EBHA_NUM_REQ-1:0] others_req;
  logic [`EBHA_NUM_IRQ-1:0] irq_prev_reg;
  logic [2:0] texp_cnt_reg;
  logic [`EBHA_TMR_W-1:0] count_prev_reg;

  assign my_line = line_of(my_num_reg);
  assign single_proc = (my_num_reg == `EBHA_ID_SINGLE);
  assign host_req = ~host_bus_request_n;
  assign my_req = core_bus_want | core_ext_req;
  assign others_req = ~multiproc_bus_request_in_n & ~my_line;

  // Processor number is caught only while reset is held.
  // Moving it outside reset would shift our request line mid-arbitration.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      my_num_reg <= multiproc_number;
    end
  end

  // Arbitration: a line wins if no higher-priority line requests.
  // Fixed order favours line 1; rotating order starts after last master.
  always_comb begin
    logic blocked;
    int k;
    k = 0;
    blocked = 1'b0;
    win = 1'b0;
    if (single_proc) begin
      win = 1'b1;
    end else if (!rotating_priority_select) begin
      for (int i = 0; i < `EBHA_NUM_REQ; i++) begin
        if (my_line[i]) begin
          win = ~blocked;
        end
        blocked = blocked | others_req[i];
      end
    end else begin
      for (int j = 1; j <= `EBHA_NUM_REQ; j++) begin
        k = (int'(last_master_reg) + j - 1) % `EBHA_NUM_REQ;
        if (my_line[k]) begin
          win = ~blocked;
        end
        blocked = blocked | others_req[k];
      end
    end
  end

  // Ownership: the host outranks every processor request.
  // A slave holds still while another master is handing the bus to the host.
  always_comb begin
    own_next = own_reg;
    unique case (own_reg)
      EBHA_OWN_SLAVE: begin
        if (host_req && host_bus_grant_in_n) begin
          own_next = own_reg;
        end else if (my_req && win && !host_req) begin
          own_next = EBHA_OWN_MASTER;
        end
      end
      EBHA_OWN_MASTER: begin
        if (host_req) begin
          own_next = EBHA_OWN_HOST;
        end else if (!my_req && !single_proc) begin
          own_next = EBHA_OWN_SLAVE;
        end
      end
      EBHA_OWN_HOST: begin
        if (!host_req) begin
          own_next = single_proc ? EBHA_OWN_MASTER : EBHA_OWN_SLAVE;
        end
      end
      default: own_next = EBHA_OWN_SLAVE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      own_reg <= EBHA_OWN_SLAVE;
      last_master_reg <= 3'h0;
    end else if (clk_en) begin
      own_reg <= own_next;
      if (own_next == EBHA_OWN_MASTER && own_reg != EBHA_OWN_MASTER &&
          !single_proc) begin
        last_master_reg <= my_num_reg;
      end
    end
  end

  // Bus request line: drive only our own line, asserted while wanting.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      multiproc_bus_request_n <= {`EBHA_NUM_REQ{1'b1}};
      multiproc_bus_request_oe <= '0;
    end else if (clk_en) begin
      multiproc_bus_request_oe <= my_line;
      multiproc_bus_request_n <=
        ~(my_line & {`EBHA_NUM_REQ{my_req}});
    end
  end

  // Host grant: driven by the master only, held low for the host.
  // Grant lags the float by a cycle, so the host never meets our drivers.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      host_bus_grant_n <= 1'b1;
      host_bus_grant_oe <= 1'b0;
    end else if (clk_en) begin
      host_bus_grant_oe <= (own_next != EBHA_OWN_SLAVE);
      host_bus_grant_n <= ~((own_next == EBHA_OWN_HOST) &&
                            (own_reg == EBHA_OWN_HOST));
    end
  end

  // Suspend is sampled, and floats the bus in the following cycle.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      suspend_reg <= 1'b0;
      bus_oe <= '0;
      core_bus_owner <= 1'b0;
    end else if (clk_en) begin
      suspend_reg <= ~bus_suspend_in_n;
      core_bus_owner <= (own_next == EBHA_OWN_MASTER);
      bus_oe <= (own_next == EBHA_OWN_MASTER && bus_suspend_in_n) ?
                '1 : '0;
    end
  end

  // External access completes only with ack high and no suspend.
  // Done is a one-cycle pulse per cycle of completion.
  // Both the sampled and the live suspend gate it, so none slips past.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      core_ext_done <= 1'b0;
    end else if (clk_en) begin
      core_ext_done <= core_ext_req && own_reg == EBHA_OWN_MASTER &&
                       ack_keep_reg && !suspend_reg &&
                       bus_suspend_in_n;
    end
  end

  // The keeper holds the last driven acknowledge level when nobody drives.
  // Our own drive is captured too, so releasing the pin keeps its level.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ack_keep_reg <= 1'b1;
    end else if (clk_en) begin
      ack_keep_reg <= ack_oe ? ack_out : ack_in;
    end
  end

  // As slave we pull acknowledge low while our memory is busy.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ack_out <= 1'b1;
      ack_oe <= 1'b0;
    end else if (clk_en) begin
      ack_oe <= (own_next == EBHA_OWN_SLAVE) && slave_sync_busy;
      ack_out <= ~slave_sync_busy;
    end
  end

  // Host ready: open-drain drives only low unless active drive is chosen.
  // Active drive also shows ready high, which open drain leaves to a pull-up.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      host_ready_out_n <= 1'b1;
      host_ready_oe <= 1'b0;
    end else if (clk_en) begin
      host_ready_out_n <= ~host_access_busy;
      host_ready_oe <= !host_cs_n && host_req &&
                       (host_access_busy || host_ack_drive_select);
    end
  end

  // Interrupts: edge mode latches a falling edge, level mode follows.
  // A new edge in the clear cycle wins over the clear.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      irq_prev_reg <= '1;
      irq_pending <= '0;
    end else if (clk_en) begin
      irq_prev_reg <= irq_in_n;
      for (int i = 0; i < `EBHA_NUM_IRQ; i++) begin
        if (irq_edge_mode[i]) begin
          if (irq_prev_reg[i] && !irq_in_n[i]) begin
            irq_pending[i] <= 1'b1;
          end else if (irq_clear[i]) begin
            irq_pending[i] <= 1'b0;
          end
        end else begin
          irq_pending[i] <= ~irq_in_n[i];
        end
      end
    end
  end

  // Flags: direction bit picks output drive or input condition.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      flag_out <= '0;
      flag_oe <= '0;
      flag_cond <= '0;
    end else if (clk_en) begin
      flag_oe <= flag_dir_out;
      flag_out <= flag_out_value;
      flag_cond <= flag_in & ~flag_dir_out;
    end
  end

  // Timer expiry: a fresh arrival at zero starts a four-cycle pulse.
  // A count parked at zero must not retrigger, hence the nonzero old count.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      count_prev_reg <= '0;
      texp_cnt_reg <= 3'h0;
      timer_expired_out <= 1'b0;
    end else if (clk_en) begin
      count_prev_reg <= timer_count_value;
      if (timer_enable && timer_count_value == '0 &&
          count_prev_reg != '0) begin
        texp_cnt_reg <= `EBHA_EXPIRE_CYC - 3'h1;
        timer_expired_out <= 1'b1;
      end else if (texp_cnt_reg != 3'h0) begin
        texp_cnt_reg <= texp_cnt_reg - 3'h1;
        timer_expired_out <= 1'b1;
      end else begin
        timer_expired_out <= 1'b0;
      end
    end
  end

  // External DMA: pair 1 maps to channel 7, pair 2 to channel 6.
  // Grants float with the rest of the bus when we are not master.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      dma_req_valid <= 2'h0;
      dma_req_channel_pair1 <= `EBHA_DMA_CH_PAIR1;
      dma_req_channel_pair2 <= `EBHA_DMA_CH_PAIR2;
      ext_dma_grant_n <= 2'h3;
      ext_dma_grant_oe <= 2'h0;
    end else if (clk_en) begin
      dma_req_valid <= ~ext_dma_request_n;
      dma_req_channel_pair1 <= `EBHA_DMA_CH_PAIR1;
      dma_req_channel_pair2 <= `EBHA_DMA_CH_PAIR2;
      ext_dma_grant_n <= ~(dma_grant_ok & ~ext_dma_request_n);
      ext_dma_grant_oe <= {2{own_next == EBHA_OWN_MASTER && bus_suspend_in_n}};
    end
  end

endmodule
`default_nettype wire

// File: ebha_partner.sv
// Purpose: Host, memory and peer side of the arbiter pins.
// Assumes: Scenario controls come from the bench at clock edges.
// Notes: Memory always drives ack, so the block's keeper is not probed.
`timescale 1ns/100ps
`default_nettype none
`include "ebha_defs.svh"
module ebha_partner (
  // Scenario controls.
  input wire logic clk,
  input wire logic host_want,
  input wire logic host_cs,
  input wire logic mem_wait,
  input wire logic peer_req,
  // Pins driven by the block.
  input wire logic ack_out,
  input wire logic ack_oe,
  input wire logic host_bus_grant_n,
  input wire logic host_bus_grant_oe,
  input wire logic [`EBHA_NUM_REQ-1:0] multiproc_bus_request_n,
  input wire logic [`EBHA_NUM_REQ-1:0] multiproc_bus_request_oe,
  // Resolved pins seen by the block.
  output logic ack_in,
  output logic host_bus_request_n,
  output logic host_cs_n,
  output logic host_bus_grant_in_n,
  output logic [`EBHA_NUM_REQ-1:0] multiproc_bus_request_in_n
);
  logic [`EBHA_NUM_REQ-1:0] pull_n;
  always @(posedge clk) begin
    host_bus_request_n <= !host_want;
    host_cs_n <= !host_cs;
  end
  // Wired-AND, since either party may hold ack low for wait states.
  assign ack_in = !mem_wait && !(ack_oe && !ack_out);
  assign host_bus_grant_in_n = host_bus_grant_oe ? host_bus_grant_n : 1'h1;
  // Line 2 is a peer's output; unused lines sit on pull-ups.
  assign pull_n = {4'hf, !peer_req, 1'h1};
  assign multiproc_bus_request_in_n =
    (multiproc_bus_request_oe & multiproc_bus_request_n) |
    (~multiproc_bus_request_oe & pull_n);
endmodule
`default_nettype wire

// File: ebha_arbiter_chk.sv
// Purpose: Timing checks on the arbiter pins.
// Assumes: One clock, synchronous active-low reset.
// Notes: Checks tie outputs to input causes, to each other, or to fixed values.
`timescale 1ns/100ps
`default_nettype none
`include "ebha_defs.svh"
module ebha_arbiter_chk
  import ebha_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Watched pins.
  input wire logic bus_suspend_in_n,
  input wire ebha_bus_oe_t bus_oe,
  input wire logic ack_in,
  input wire logic core_ext_done,
  input wire logic host_bus_request_n,
  input wire logic host_cs_n,
  input wire logic host_ack_drive_select,
  input wire logic host_bus_grant_n,
  input wire logic host_ready_out_n,
  input wire logic host_ready_oe,
  input wire logic [`EBHA_NUM_REQ-1:0] multiproc_bus_request_oe,
  input wire logic timer_expired_out,
  input wire logic [2:0] dma_req_channel_pair1,
  input wire logic [2:0] dma_req_channel_pair2
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  susp_float_a: assert property (
    !bus_suspend_in_n |=> bus_oe == 4'h0)
    else $error("Bus driven under suspend.");
  susp_stall_a: assert property (
    !bus_suspend_in_n |=> !core_ext_done)
    else $error("Access done under suspend.");
  ack_wait_a: assert property (
    !ack_in ##1 !ack_in |=> !core_ext_done)
    else $error("Access done while ack low.");
  grant_float_a: assert property (
    !host_bus_grant_n |-> bus_oe == 4'h0)
    else $error("Bus driven while host granted.");
  grant_cause_a: assert property (
    !host_bus_grant_n |-> !$past(host_bus_request_n))
    else $error("Grant without host request.");
  grant_hold_a: assert property (
    !host_bus_grant_n && !host_bus_request_n |=> !host_bus_grant_n)
    else $error("Grant dropped early.");
  ready_gate_a: assert property (
    host_ready_oe |-> !$past(host_cs_n) && !$past(host_bus_request_n))
    else $error("Ready driven without select.");
  ready_od_a: assert property (
    host_ready_oe && !$past(host_ack_drive_select) |-> !host_ready_out_n)
    else $error("Open-drain ready driven high.");
  own_line_a: assert property (
    $onehot0(multiproc_bus_request_oe))
    else $error("More than one request line driven.");
  timer_len_a: assert property (
    $rose(timer_expired_out) |-> timer_expired_out[*4] ##1 !timer_expired_out)
    else $error("Timer pulse not four cycles.");
  dma_chan_a: assert property (
    dma_req_channel_pair1 == `EBHA_DMA_CH_PAIR1 &&
    dma_req_channel_pair2 == `EBHA_DMA_CH_PAIR2)
    else $error("DMA channel mapping wrong.");
endmodule
bind ebha_arbiter ebha_arbiter_chk chk (.*);
`default_nettype wire

// File: ebha_arbiter_tb.sv
// Purpose: Self-checking bench for the bus handshake arbiter.
// Assumes: Processor number 1; host and memory come from ebha_partner.
// Notes: Inputs change at rising edges; checks look 1 ns later.
`timescale 1ns/100ps
`default_nettype none
`include "ebha_defs.svh"
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin \
  bad_count++; $display("Error %s expected %h seen %h", nm, ex, got); end end
`define WAITC(c) begin n = 0; #1; while (((c) !== 1'b1) && n < 40) begin \
  tick(1); n++; end if ((c) !== 1'b1) begin bad_count++; close_out(); end end
module ebha_arbiter_tb;
  import ebha_pkg::*;
  int bad_count = 0;
  int samples_checked = 0;
  int n;
  logic clk = 0, rst_b = 0, clk_en = 1, rotating_priority_select = 0;
  logic host_ack_drive_select = 0, core_ext_req = 0, core_bus_want = 0;
  logic slave_sync_busy = 0, bus_suspend_in_n = 1, host_access_busy = 0;
  logic [2:0] multiproc_number = 3'h1, irq_in_n = 3'h7;
  logic [2:0] irq_edge_mode = 3'h1, irq_clear = 3'h0;
  logic [3:0] flag_dir_out = 4'h0, flag_out_value = 4'h0, flag_in = 4'h0;
  logic timer_enable = 0;
  logic [31:0] timer_count_value = 32'h0000_0009;
  logic [1:0] ext_dma_request_n = 2'h3, dma_grant_ok = 2'h0;
  logic host_want = 0, host_cs = 0, mem_wait = 0, peer_req = 0;
  logic core_ext_done, core_bus_owner, ack_in, ack_out, ack_oe;
  ebha_bus_oe_t bus_oe;
  logic host_bus_request_n, host_cs_n, host_bus_grant_in_n;
  logic host_bus_grant_n, host_bus_grant_oe, host_ready_out_n, host_ready_oe;
  logic [5:0] multiproc_bus_request_in_n, multiproc_bus_request_n;
  logic [5:0] multiproc_bus_request_oe;
  logic [2:0] irq_pending, dma_req_channel_pair1, dma_req_channel_pair2;
  logic [3:0] flag_out, flag_oe, flag_cond;
  logic timer_expired_out;
  logic [1:0] ext_dma_grant_n, ext_dma_grant_oe, dma_req_valid;
  ebha_arbiter dut (.*);
  ebha_partner far (.*);
  initial begin
    forever #25 clk = ~clk;
  end
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic count_done(input int k, output int c);
    c = 0;
    repeat (k) begin
      tick(1);
      c += (core_ext_done === 1'b1);
    end
  endtask
  task automatic close_out();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    tick(4);
    @(posedge clk) rst_b <= 1;
    tick(1);
    `CHK("bus_oe", 4'h0, bus_oe)
    `CHK("grant", 1'b1, host_bus_grant_n)
    @(posedge clk) slave_sync_busy <= 1;
    tick(2);
    `CHK("ack_oe", 1'b1, ack_oe)
    `CHK("ack_out", 1'b0, ack_out)
    @(posedge clk) slave_sync_busy <= 0;
    @(posedge clk) core_bus_want <= 1;
    `WAITC(core_bus_owner)
    `CHK("req_oe", 6'h01, multiproc_bus_request_oe)
    `CHK("req_n", 6'h3e, multiproc_bus_request_n)
    @(posedge clk) mem_wait <= 1;
    @(posedge clk) core_ext_req <= 1;
    count_done(6, n);
    `CHK("done_wait", 0, n)
    @(posedge clk) mem_wait <= 0;
    `WAITC(core_ext_done)
    @(posedge clk) bus_suspend_in_n <= 0;
    tick(1);
    count_done(4, n);
    `CHK("done_susp", 0, n)
    `CHK("bus_oe_susp", 4'h0, bus_oe)
    @(posedge clk) bus_suspend_in_n <= 1;
    count_done(6, n);
    `CHK("done_free", 1'b1, n > 0)
    @(posedge clk) core_ext_req <= 0;
    @(posedge clk) host_want <= 1;
    @(posedge clk) peer_req <= 1;
    `WAITC(!host_bus_grant_n)
    `CHK("bus_oe_host", 4'h0, bus_oe)
    `CHK("owner_host", 1'b0, core_bus_owner)
    `CHK("grant_oe", 1'b1, host_bus_grant_oe)
    @(posedge clk) host_cs <= 1;
    @(posedge clk) host_access_busy <= 1;
    tick(3);
    `CHK("rdy_oe", 1'b1, host_ready_oe)
    `CHK("rdy_n", 1'b0, host_ready_out_n)
    @(posedge clk) host_access_busy <= 0;
    tick(2);
    `CHK("rdy_od", 1'b0, host_ready_oe)
    @(posedge clk) host_ack_drive_select <= 1;
    tick(2);
    `CHK("rdy_ad", 1'b1, host_ready_oe)
    `CHK("rdy_hi", 1'b1, host_ready_out_n)
    @(posedge clk) host_cs <= 0;
    tick(3);
    `CHK("rdy_cs", 1'b0, host_ready_oe)
    `CHK("grant_held", 1'b0, host_bus_grant_n)
    @(posedge clk) host_want <= 0;
    `WAITC(host_bus_grant_n)
    @(posedge clk) timer_enable <= 1;
    @(posedge clk) timer_count_value <= 32'h0000_0000;
    count_done(0, n);
    repeat (8) begin
      tick(1);
      n += (timer_expired_out === 1'b1);
    end
    `CHK("tmr_len", 4, n)
    @(posedge clk) irq_in_n <= 3'h4;
    @(posedge clk) irq_in_n <= 3'h5;
    tick(2);
    `CHK("irq_set", 3'h3, irq_pending)
    @(posedge clk) irq_in_n <= 3'h7;
    @(posedge clk) irq_clear <= 3'h1;
    @(posedge clk) irq_clear <= 3'h0;
    tick(2);
    `CHK("irq_clr", 3'h0, irq_pending)
    @(posedge clk) flag_dir_out <= 4'h5;
    @(posedge clk) flag_out_value <= 4'hf;
    @(posedge clk) flag_in <= 4'ha;
    tick(2);
    `CHK("flag_oe", 4'h5, flag_oe)
    `CHK("flag_out", 4'h5, flag_out & flag_oe)
    `CHK("flag_cond", 4'ha, flag_cond & 4'ha)
    @(posedge clk) ext_dma_request_n <= 2'h2;
    @(posedge clk) dma_grant_ok <= 2'h1;
    tick(3);
    `CHK("dma_v", 2'h1, dma_req_valid)
    `CHK("dma_ch", 3'h7, dma_req_channel_pair1)
    `CHK("dma_ch2", 3'h6, dma_req_channel_pair2)
    `CHK("dma_gnt", 2'h2, ext_dma_grant_n)
    `CHK("dma_goe", 2'h3, ext_dma_grant_oe)
    @(posedge clk) core_bus_want <= 0;
    @(posedge clk) rotating_priority_select <= 1;
    @(posedge clk) core_bus_want <= 1;
    tick(3);
    `CHK("owner_rot", 1'b0, core_bus_owner)
    @(posedge clk) rotating_priority_select <= 0;
    tick(2);
    `CHK("owner_fix", 1'b1, core_bus_owner)
    close_out();
  end
endmodule
`default_nettype wire
